// ==== sim/core_model.sv ====
`timescale 1ns/1ps
// Core side of the trace unit: one retire or exception event per request
module core_model (
  input wire logic clk_i,
  input wire logic ev_ready_i,
  output logic exc_start_o,
  output trc_pkg::exc_kind_type exc_kind_o,
  output logic [8:0] exc_type_o,
  output logic [63:0] exc_pra_o,
  output logic exc_replace_o,
  output logic exc_taken_o,
  output logic [63:0] exc_vector_o,
  output logic lockup_o,
  output trc_pkg::lock_cause_type lockup_cause_o,
  output logic [63:0] lockup_addr_o,
  output logic insn_valid_o,
  output trc_pkg::insn_class_type insn_class_o,
  output logic insn_taken_o,
  output logic insn_cond_fail_o,
  output logic [63:0] insn_target_o,
  output logic target_64_o,
  output logic rstack_match_o
);
  // Quiet until the bench asks for an event
  initial begin
    {exc_start_o, exc_replace_o, exc_taken_o, lockup_o} = 4'h0;
    {insn_valid_o, insn_taken_o, insn_cond_fail_o} = 3'h0;
    {target_64_o, rstack_match_o} = 2'h0;
    exc_kind_o = trc_pkg::EK_NORMAL;
    lockup_cause_o = trc_pkg::LC_INSN;
    insn_class_o = trc_pkg::IC_OTHER;
    {exc_type_o, exc_pra_o, exc_vector_o} = '0;
    {lockup_addr_o, insn_target_o} = '0;
  end

  // Hold until taken; released address buses show their inverse, type, kind, class and cause keep stale values
  task automatic fire();
    bit ok;
    ok = 1'b0;
    while (!ok) begin
      @(posedge clk_i);
      ok = ev_ready_i;
    end
    @(negedge clk_i);
    {exc_start_o, exc_replace_o, exc_taken_o, lockup_o} = 4'h0;
    {insn_valid_o, insn_taken_o, insn_cond_fail_o} = 3'h0;
    exc_pra_o = ~exc_pra_o;
    exc_vector_o = ~exc_vector_o;
    lockup_addr_o = ~lockup_addr_o;
    insn_target_o = ~insn_target_o;
  endtask : fire

  task automatic start(trc_pkg::exc_kind_type k, logic [8:0] t,
    logic [63:0] p);
    @(negedge clk_i);
    exc_kind_o = k;
    exc_type_o = t;
    exc_pra_o = p;
    exc_start_o = 1'b1;
    fire();
  endtask : start

  task automatic replace(logic [8:0] t);
    @(negedge clk_i);
    exc_type_o = t;
    exc_replace_o = 1'b1;
    fire();
  endtask : replace

  task automatic take(logic [63:0] v);
    @(negedge clk_i);
    exc_vector_o = v;
    exc_taken_o = 1'b1;
    fire();
  endtask : take

  task automatic lock(trc_pkg::lock_cause_type c, logic [63:0] a);
    @(negedge clk_i);
    lockup_cause_o = c;
    lockup_addr_o = a;
    lockup_o = 1'b1;
    fire();
  endtask : lock

  task automatic insn(trc_pkg::insn_class_type c, logic [63:0] t,
    logic cf, logic t64, logic rs);
    @(negedge clk_i);
    insn_class_o = c;
    insn_target_o = t;
    insn_cond_fail_o = cf;
    target_64_o = t64;
    rstack_match_o = rs;
    insn_taken_o = 1'b1;
    insn_valid_o = 1'b1;
    fire();
  endtask : insn
endmodule : core_model

// ==== sim/exc_trace_gen_test.sv ====
`timescale 1ns/1ps
// Self-checking bench for the exception and address element generator
module exc_trace_gen_test;
  typedef struct packed {
    logic [2:0] k;
    logic [63:0] a;
    logic [8:0] t;
    logic [2:0] f;
    logic s;
    logic c;
  } seen_type;
  // Return recognition: profile, class, loaded value, condition, result
  typedef struct {
    logic mcu;
    trc_pkg::insn_class_type cls;
    logic [31:0] pc;
    logic cf;
    logic hit;
    logic spec;
  } row_type;
  row_type rows [8] = '{
    '{1'b1, trc_pkg::IC_MULTI_LOAD_PC, 32'hF000_0020, 1'b0, 1'b1, 1'b1},
    '{1'b1, trc_pkg::IC_SINGLE_LOAD_PC, 32'hFFFF_FFF9, 1'b0, 1'b1, 1'b1},
    '{1'b1, trc_pkg::IC_REG_BRANCH_EXCHANGE, 32'hFFFF_FFFD, 1'b0, 1'b1, 1'b1},
    '{1'b1, trc_pkg::IC_REG_BRANCH_EXCHANGE, 32'hEFFF_FFFD, 1'b0, 1'b0, 1'b0},
    '{1'b1, trc_pkg::IC_OTHER, 32'hFFFF_FFF9, 1'b0, 1'b0, 1'b0},
    '{1'b1, trc_pkg::IC_REG_BRANCH_EXCHANGE, 32'hFFFF_FFF9, 1'b1, 1'b0, 1'b0},
    '{1'b0, trc_pkg::IC_ERET, 32'h0000_1000, 1'b0, 1'b1, 1'b0},
    '{1'b0, trc_pkg::IC_ERET, 32'h0000_1000, 1'b1, 1'b1, 1'b0}
  };
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce_i = 1'b0;
  logic trace_active_i = 1'b1;
  logic mcu_profile_i = 1'b1;
  logic bb_mode_i = 1'b0;
  logic tbi_i = 1'b0;
  logic tbi_sext_i = 1'b0;
  logic cur_64_i = 1'b0;
  logic [2:0] pend = 3'h0;
  logic [4:0] side = 5'h08;
  logic exc_start_i, exc_replace_i, exc_taken_i, lockup_i, insn_valid_i;
  logic insn_taken_i, insn_cond_fail_i, target_64_i, rstack_match_i;
  logic [8:0] exc_type_i;
  logic [63:0] exc_pra_i, exc_vector_i, lockup_addr_i, insn_target_i;
  trc_pkg::exc_kind_type exc_kind_i;
  trc_pkg::lock_cause_type lockup_cause_i;
  trc_pkg::insn_class_type insn_class_i;
  logic ev_ready_o, elem_valid_o, elem_spec_o, ctx_req_o, locked_o;
  trc_pkg::elem_kind_type elem_kind_o;
  logic [63:0] elem_addr_o;
  logic [8:0] elem_exc_type_o;
  logic [2:0] elem_fault_o;
  seen_type q[$];
  seen_type cur;
  logic hit;
  int err_count = 0;
  int num_checks = 0;

  always #2 clk_i = ~clk_i;

  exc_trace_gen i_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .trace_active_i(trace_active_i), .mcu_profile_i(mcu_profile_i),
    .bb_mode_i(bb_mode_i), .addr_after_sync_i(side[4]), .tbi_i(tbi_i),
    .tbi_sext_i(tbi_sext_i), .cur_64_i(cur_64_i),
    .unrec_pend_i(pend[2]), .bus_pend_i(pend[1]), .prot_pend_i(pend[0]),
    .exc_start_i(exc_start_i), .exc_kind_i(exc_kind_i),
    .exc_type_i(exc_type_i), .exc_pra_i(exc_pra_i),
    .exc_replace_i(exc_replace_i), .exc_taken_i(exc_taken_i),
    .exc_vector_i(exc_vector_i), .lockup_i(lockup_i),
    .lockup_cause_i(lockup_cause_i), .lockup_addr_i(lockup_addr_i),
    .insn_valid_i(insn_valid_i), .insn_class_i(insn_class_i),
    .insn_taken_i(insn_taken_i), .insn_cond_fail_i(insn_cond_fail_i),
    .insn_target_i(insn_target_i), .target_64_i(target_64_i),
    .rstack_match_i(rstack_match_i), .target_active_i(side[3]),
    .q_elem_i(side[2]), .mispred_i(side[1]), .trace_sync_i(side[0]),
    .ev_ready_o(ev_ready_o), .elem_valid_o(elem_valid_o),
    .elem_kind_o(elem_kind_o), .elem_addr_o(elem_addr_o),
    .elem_exc_type_o(elem_exc_type_o), .elem_fault_o(elem_fault_o),
    .elem_spec_o(elem_spec_o), .elem_key_o(), .ctx_req_o(ctx_req_o),
    .locked_o(locked_o)
  );

  core_model i_core (
    .clk_i(clk_i), .ev_ready_i(ev_ready_o & ce_i),
    .exc_start_o(exc_start_i), .exc_kind_o(exc_kind_i),
    .exc_type_o(exc_type_i), .exc_pra_o(exc_pra_i),
    .exc_replace_o(exc_replace_i), .exc_taken_o(exc_taken_i),
    .exc_vector_o(exc_vector_i), .lockup_o(lockup_i),
    .lockup_cause_o(lockup_cause_i), .lockup_addr_o(lockup_addr_i),
    .insn_valid_o(insn_valid_i), .insn_class_o(insn_class_i),
    .insn_taken_o(insn_taken_i), .insn_cond_fail_o(insn_cond_fail_i),
    .insn_target_o(insn_target_i), .target_64_o(target_64_i),
    .rstack_match_o(rstack_match_i)
  );

  // Log elements; frozen cycles repeat, skip them
  always @(posedge clk_i) begin
    if (elem_valid_o === 1'b1 && ce_i === 1'b1) begin
      q.push_back({elem_kind_o, elem_addr_o, elem_exc_type_o,
        elem_fault_o, elem_spec_o, ctx_req_o});
    end
  end

  task automatic cmp(string n, logic [63:0] e, logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  // Let the stream settle, then look for the next element of one kind
  task automatic find(logic [2:0] k);
    repeat (12) @(negedge clk_i);
    hit = 1'b0;
    while (q.size() > 0 && !hit) begin
      cur = q.pop_front();
      hit = (cur.k === k);
    end
  endtask : find

  task automatic chk(logic [2:0] k, logic [63:0] a);
    find(k);
    cmp("found", 64'h1, hit);
    cmp("addr", a, cur.a);
  endtask : chk

  task automatic br(trc_pkg::insn_class_type c, logic [63:0] t,
    logic t64, logic rs, logic e, logic [63:0] ea);
    q.delete();
    i_core.insn(c, t, 1'b0, t64, rs);
    find(trc_pkg::EL_ADDR);
    cmp("addr found", e, hit);
    if (hit) cmp("addr", ea, cur.a);
  endtask : br

  // ce_i low one cycle after release
  task automatic rst();
    arst_n_i = 1'b0;
    ce_i = 1'b0;
    repeat (16) @(negedge clk_i);
    cmp("valid", 64'h0, elem_valid_o);
    cmp("locked", 64'h0, locked_o);
    arst_n_i = 1'b1;
    @(negedge clk_i);
    ce_i = 1'b1;
    q.delete();
  endtask : rst

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // Cap; the run needs about 600 cycles
  initial begin
    #80000;
    err_count++;
    complete_run();
  end

  initial begin
    rst();
    foreach (rows[i]) begin
      @(negedge clk_i);
      mcu_profile_i = rows[i].mcu;
      q.delete();
      i_core.insn(rows[i].cls, {32'h0, rows[i].pc}, rows[i].cf, 1'b0, 1'b0);
      find(trc_pkg::EL_EXRET);
      cmp("exret", rows[i].hit, hit);
      if (hit) cmp("spec", rows[i].spec, cur.s);
    end
    // Exception kinds, each with one fault pending
    @(negedge clk_i);
    mcu_profile_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      pend = 3'h1 << i;
      q.delete();
      i_core.start(trc_pkg::exc_kind_type'(i), 9'h010, 64'h2000);
      i_core.take(64'h400);
      chk(trc_pkg::EL_EXC, i > 0 ? trc_pkg::NO_EXEC_ADDR : 64'h2000);
      cmp("fault", pend, cur.f);
      chk(trc_pkg::EL_ADDR, 64'h400);
    end
    pend = 3'h0;
    // Late and derived replacements: only the final one is reported
    q.delete();
    i_core.start(trc_pkg::EK_NORMAL, 9'h021, 64'h3000);
    i_core.replace(9'h022);
    i_core.replace(9'h023);
    i_core.take(64'h500);
    chk(trc_pkg::EL_EXC, 64'h3000);
    cmp("type", 9'h023, cur.t);
    find(trc_pkg::EL_EXC);
    cmp("second exc", 64'h0, hit);
    // Lockup from an instruction, silence inside, exit by exception
    q.delete();
    i_core.lock(trc_pkg::LC_INSN, 64'h4000);
    chk(trc_pkg::EL_EXC, 64'h4000);
    cmp("type", trc_pkg::LOCKUP_TYPE, cur.t);
    cmp("locked", 64'h1, locked_o);
    q.delete();
    i_core.insn(trc_pkg::IC_INDIRECT, 64'h6000, 1'b0, 1'b0, 1'b0);
    repeat (12) @(negedge clk_i);
    cmp("in lockup", 64'h0, q.size());
    i_core.start(trc_pkg::EK_NORMAL, 9'h005, 64'h7000);
    i_core.take(64'h600);
    chk(trc_pkg::EL_EXC, 64'h4000);
    cmp("locked", 64'h0, locked_o);
    // Untraced lockup; exit once tracing is on uses lockup address
    rst();
    trace_active_i = 1'b0;
    i_core.lock(trc_pkg::LC_INSN, 64'h4200);
    find(trc_pkg::EL_EXC);
    cmp("quiet lockup", 64'h0, hit);
    trace_active_i = 1'b1;
    i_core.start(trc_pkg::EK_NORMAL, 9'h007, 64'h7100);
    i_core.take(64'h700);
    chk(trc_pkg::EL_EXC, 64'h4200);
    // Lockup caused by exception entry and by exception return
    rst();
    i_core.start(trc_pkg::EK_NORMAL, 9'h006, 64'h8000);
    i_core.lock(trc_pkg::LC_ENTRY, 64'h4100);
    chk(trc_pkg::EL_EXC, 64'h8000);
    chk(trc_pkg::EL_EXC, trc_pkg::NO_EXEC_ADDR);
    cmp("type", trc_pkg::LOCKUP_TYPE, cur.t);
    rst();
    i_core.lock(trc_pkg::LC_RETURN, 64'h4300);
    chk(trc_pkg::EL_EXC, trc_pkg::NO_EXEC_ADDR);
    cmp("type", trc_pkg::LOCKUP_TYPE, cur.t);
    // Address elements: needed, omitted, redundant, tagged, invalid
    rst();
    br(trc_pkg::IC_INDIRECT, 64'h9000, 1'b0, 1'b0, 1'b1, 64'h9000);
    br(trc_pkg::IC_INDIRECT, 64'h9100, 1'b0, 1'b1, 1'b0, 64'h0);
    br(trc_pkg::IC_DIRECT, 64'h9200, 1'b0, 1'b0, 1'b0, 64'h0);
    bb_mode_i = 1'b1;
    br(trc_pkg::IC_DIRECT, 64'h9300, 1'b0, 1'b0, 1'b1, 64'h9300);
    br(trc_pkg::IC_SYNC_BARRIER, 64'h9400, 1'b0, 1'b0, 1'b1, 64'h9400);
    bb_mode_i = 1'b0;
    br(trc_pkg::IC_INDIRECT, 64'h9500, 1'b1, 1'b0, 1'b1, 64'h9500);
    cmp("context", 64'h1, cur.c);
    cur_64_i = 1'b1;
    br(trc_pkg::IC_INDIRECT, 64'h9600, 1'b1, 1'b0, 1'b1, 64'h9600);
    tbi_i = 1'b1;
    tbi_sext_i = 1'b1;
    br(trc_pkg::IC_INDIRECT, 64'h5AFF_FF80_0000_2000, 1'b1, 1'b0, 1'b1,
      64'hFFFF_FF80_0000_2000);
    tbi_sext_i = 1'b0;
    br(trc_pkg::IC_INDIRECT, 64'h5A00_0000_0000_2000, 1'b1, 1'b0, 1'b1,
      64'h0000_0000_0000_2000);
    tbi_i = 1'b0;
    br(trc_pkg::IC_INDIRECT, 64'h1234_0000_0000_3000, 1'b1, 1'b0, 1'b1,
      64'h1234_0000_0000_3000);
    complete_run();
  end
endmodule : exc_trace_gen_test

// ==== verilog/addr_sanitize.sv ====
`timescale 1ns/1ps
// Untags a traced virtual address unless it is non-canonical
module addr_sanitize (
  input wire logic [63:0] addr_i,
  input wire logic tbi_i,
  input wire logic tbi_sext_i,
  output logic [63:0] addr_o,
  output logic invalid_o
);
  wire [7:0] top_fill;
  wire [63:0] untagged;
  wire [15:0] hi;

  // Invalid addresses keep every bit; a tag alone is not invalid
  assign hi = tbi_i ? untagged[63:48] : addr_i[63:48];
  assign invalid_o = (hi != trc_pkg::CANON_LO) &&
                     (hi != trc_pkg::CANON_HI);
  assign top_fill = tbi_sext_i ? {8{addr_i[55]}} : 8'h00;
  assign untagged = {top_fill, addr_i[55:0]};
  assign addr_o = (tbi_i && !invalid_o) ? untagged : addr_i;
endmodule : addr_sanitize

// ==== verilog/exc_trace_gen.sv ====
`timescale 1ns/1ps
// Exception, exception-return and address element generator
module exc_trace_gen (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic trace_active_i,
  input wire logic mcu_profile_i,
  input wire logic bb_mode_i,
  input wire logic addr_after_sync_i,
  input wire logic tbi_i,
  input wire logic tbi_sext_i,
  input wire logic cur_64_i,
  input wire logic unrec_pend_i,
  input wire logic bus_pend_i,
  input wire logic prot_pend_i,
  input wire logic exc_start_i,
  input wire trc_pkg::exc_kind_type exc_kind_i,
  input wire logic [8:0] exc_type_i,
  input wire logic [63:0] exc_pra_i,
  input wire logic exc_replace_i,
  input wire logic exc_taken_i,
  input wire logic [63:0] exc_vector_i,
  input wire logic lockup_i,
  input wire trc_pkg::lock_cause_type lockup_cause_i,
  input wire logic [63:0] lockup_addr_i,
  input wire logic insn_valid_i,
  input wire trc_pkg::insn_class_type insn_class_i,
  input wire logic insn_taken_i,
  input wire logic insn_cond_fail_i,
  input wire logic [63:0] insn_target_i,
  input wire logic target_64_i,
  input wire logic rstack_match_i,
  input wire logic target_active_i,
  input wire logic q_elem_i,
  input wire logic mispred_i,
  input wire logic trace_sync_i,
  output logic ev_ready_o,
  output logic elem_valid_o,
  output trc_pkg::elem_kind_type elem_kind_o,
  output logic [63:0] elem_addr_o,
  output logic [8:0] elem_exc_type_o,
  output logic [2:0] elem_fault_o,
  output logic elem_spec_o,
  output logic [3:0] elem_key_o,
  output logic ctx_req_o,
  output logic locked_o
);
  // Entry being built, pending second element and pending address
  logic pend_q, pend_d;
  logic [8:0] ptype_q, ptype_d;
  logic [63:0] ppra_q, ppra_d;
  logic sec_q, sec_d;
  trc_pkg::elem_kind_type skind_q, skind_d;
  logic [63:0] saddr_q, saddr_d;
  logic [8:0] stype_q, stype_d;
  logic sspec_q, sspec_d;
  logic apend_q, apend_d;
  logic [63:0] aaddr_q, aaddr_d;
  logic a64_q, a64_d;
  logic lock_q, lock_d;
  logic lact_q, lact_d;
  logic [63:0] laddr_q, laddr_d;
  logic [3:0] key_q, key_d;
  logic ov_q, ov_d;
  trc_pkg::elem_kind_type okind_q, okind_d;
  logic [63:0] oaddr_q, oaddr_d;
  logic [8:0] otype_q, otype_d;
  logic [2:0] ofault_q, ofault_d;
  logic ospec_q, ospec_d;
  logic [3:0] okey_q, okey_d;
  logic octx_q, octx_d;

  wire acc;
  wire is_exret;
  wire [63:0] clean_target;
  wire [63:0] clean_vector;
  wire [63:0] start_pra;
  wire [2:0] faults;
  wire br_atom;
  wire need_addr;
  wire [63:0] need_val;
  wire need_64;

  exret_detect u_exret (
    .mcu_profile_i(mcu_profile_i),
    .class_i(insn_class_i),
    .pc_load_i(insn_target_i[31:0]),
    .cond_fail_i(insn_cond_fail_i),
    .is_exret_o(is_exret)
  );

  addr_sanitize u_tgt_clean (
    .addr_i(insn_target_i),
    .tbi_i(tbi_i),
    .tbi_sext_i(tbi_sext_i),
    .addr_o(clean_target),
    .invalid_o()
  );

  addr_sanitize u_vec_clean (
    .addr_i(exc_vector_i),
    .tbi_i(tbi_i),
    .tbi_sext_i(tbi_sext_i),
    .addr_o(clean_vector),
    .invalid_o()
  );

  // A held element or a pending address stalls the core for a cycle
  assign acc = ce_i && !sec_q && !apend_q;
  assign ev_ready_o = !sec_q && !apend_q;
  assign faults = {unrec_pend_i, bus_pend_i, prot_pend_i};

  // Return address chosen once when entry starts
  assign start_pra = lock_q ? laddr_q :
                     (exc_kind_i == trc_pkg::EK_NORMAL) ? exc_pra_i :
                     trc_pkg::NO_EXEC_ADDR;

  assign br_atom = insn_valid_i && ((insn_class_i == trc_pkg::IC_DIRECT) ||
                   (insn_class_i == trc_pkg::IC_INDIRECT) ||
                   (insn_class_i == trc_pkg::IC_SYNC_BARRIER));

  // Address needed when the target cannot be inferred
  assign need_addr = trace_active_i && target_active_i && !rstack_match_i &&
    ((insn_valid_i && insn_taken_i &&
      ((insn_class_i == trc_pkg::IC_INDIRECT) ||
       (bb_mode_i && ((insn_class_i == trc_pkg::IC_DIRECT) ||
        (insn_class_i == trc_pkg::IC_SYNC_BARRIER))))) ||
     exc_taken_i || mispred_i || q_elem_i ||
     (trace_sync_i && addr_after_sync_i));
  assign need_val = exc_taken_i ? clean_vector : clean_target;
  assign need_64 = exc_taken_i ? cur_64_i : target_64_i;

  // Next-state decode for the entry tracker and lockup
  always_comb begin
    pend_d = pend_q;
    ptype_d = ptype_q;
    ppra_d = ppra_q;
    lock_d = lock_q;
    lact_d = lact_q;
    laddr_d = laddr_q;
    if (acc && exc_start_i) begin
      pend_d = 1'b1;
      ptype_d = exc_type_i;
      ppra_d = start_pra;
    end else if (acc && pend_q && exc_replace_i) begin
      ptype_d = exc_type_i;
    end
    if (acc && exc_taken_i) begin
      pend_d = 1'b0;
      lock_d = 1'b0;
    end
    if (acc && lockup_i) begin
      pend_d = 1'b0;
      lock_d = 1'b1;
      lact_d = trace_active_i;
      laddr_d = lockup_addr_i;
    end
  end

  // Output element selection, one element per cycle
  always_comb begin
    ov_d = 1'b0;
    okind_d = trc_pkg::EL_NONE;
    oaddr_d = oaddr_q;
    otype_d = otype_q;
    ofault_d = ofault_q;
    ospec_d = 1'b0;
    okey_d = okey_q;
    octx_d = 1'b0;
    sec_d = sec_q;
    skind_d = skind_q;
    saddr_d = saddr_q;
    stype_d = stype_q;
    sspec_d = sspec_q;
    apend_d = apend_q;
    aaddr_d = aaddr_q;
    a64_d = a64_q;
    key_d = key_q;
    if (!ce_i) begin
      ov_d = ov_q;
      okind_d = okind_q;
      ospec_d = ospec_q;
      octx_d = octx_q;
    end else if (sec_q) begin
      ov_d = 1'b1;
      okind_d = skind_q;
      oaddr_d = saddr_q;
      otype_d = stype_q;
      ofault_d = faults;
      ospec_d = sspec_q;
      okey_d = key_q;
      key_d = sspec_q ? 4'(key_q + 4'h1) : key_q;
      sec_d = 1'b0;
    end else if (apend_q) begin
      ov_d = 1'b1;
      okind_d = trc_pkg::EL_ADDR;
      oaddr_d = aaddr_q;
      octx_d = a64_q && !cur_64_i;
      apend_d = 1'b0;
    end else begin
      if (need_addr && !(lock_q && !exc_taken_i)) begin
        apend_d = 1'b1;
        aaddr_d = need_val;
        a64_d = need_64;
      end
      if (lockup_i && trace_active_i) begin
        // Entry-caused lockup: the exception goes first, lockup second
        if (lockup_cause_i == trc_pkg::LC_ENTRY && pend_q) begin
          ov_d = 1'b1;
          okind_d = trc_pkg::EL_EXC;
          oaddr_d = ppra_q;
          otype_d = ptype_q;
          ofault_d = faults;
          ospec_d = 1'b1;
          okey_d = key_q;
          key_d = 4'(key_q + 4'h1);
          sec_d = 1'b1;
          skind_d = trc_pkg::EL_EXC;
          saddr_d = trc_pkg::NO_EXEC_ADDR;
          stype_d = trc_pkg::LOCKUP_TYPE;
          sspec_d = 1'b1;
        end else begin
          ov_d = 1'b1;
          okind_d = trc_pkg::EL_EXC;
          oaddr_d = (lockup_cause_i == trc_pkg::LC_INSN) ?
                    lockup_addr_i : trc_pkg::NO_EXEC_ADDR;
          otype_d = trc_pkg::LOCKUP_TYPE;
          ofault_d = faults;
          ospec_d = 1'b1;
          okey_d = key_q;
          key_d = 4'(key_q + 4'h1);
        end
      end else if (exc_taken_i && pend_q && (trace_active_i ||
                   (lock_q && lact_q))) begin
        ov_d = 1'b1;
        okind_d = trc_pkg::EL_EXC;
        oaddr_d = ppra_q;
        otype_d = ptype_q;
        ofault_d = faults;
        ospec_d = 1'b1;
        okey_d = key_q;
        key_d = 4'(key_q + 4'h1);
      end else if (lock_q || !trace_active_i) begin
        ov_d = 1'b0;
      end else if (insn_valid_i && is_exret && mcu_profile_i) begin
        ov_d = 1'b1;
        okind_d = trc_pkg::EL_EXRET;
        oaddr_d = insn_target_i;
        ospec_d = 1'b1;
        okey_d = key_q;
        key_d = 4'(key_q + 4'h1);
      end else if (insn_valid_i && (br_atom || is_exret)) begin
        ov_d = 1'b1;
        okind_d = (insn_taken_i && !insn_cond_fail_i) ?
                  trc_pkg::EL_ATOM_E : trc_pkg::EL_ATOM_N;
        ospec_d = 1'b1;
        okey_d = key_q;
        key_d = 4'(key_q + 4'h1);
        if (is_exret) begin
          sec_d = 1'b1;
          skind_d = trc_pkg::EL_EXRET;
          saddr_d = insn_target_i;
          stype_d = otype_q;
          sspec_d = 1'b0;
        end
      end else if (q_elem_i) begin
        ov_d = 1'b1;
        okind_d = trc_pkg::EL_Q;
        ospec_d = 1'b1;
        okey_d = key_q;
        key_d = 4'(key_q + 4'h1);
      end
    end
  end

  // Tracker state; clock enable freezes everything
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_q <= 1'b0;
      ptype_q <= 9'h000;
      ppra_q <= trc_pkg::ADDR_RST;
      lock_q <= 1'b0;
      lact_q <= 1'b0;
      laddr_q <= trc_pkg::ADDR_RST;
    end else if (ce_i) begin
      pend_q <= pend_d;
      ptype_q <= ptype_d;
      ppra_q <= ppra_d;
      lock_q <= lock_d;
      lact_q <= lact_d;
      laddr_q <= laddr_d;
    end
  end

  // Held elements and the key counter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sec_q <= 1'b0;
      skind_q <= trc_pkg::EL_NONE;
      saddr_q <= trc_pkg::ADDR_RST;
      stype_q <= 9'h000;
      sspec_q <= 1'b0;
      apend_q <= 1'b0;
      aaddr_q <= trc_pkg::ADDR_RST;
      a64_q <= 1'b0;
      key_q <= trc_pkg::KEY_RST;
    end else if (ce_i) begin
      sec_q <= sec_d;
      skind_q <= skind_d;
      saddr_q <= saddr_d;
      stype_q <= stype_d;
      sspec_q <= sspec_d;
      apend_q <= apend_d;
      aaddr_q <= aaddr_d;
      a64_q <= a64_d;
      key_q <= key_d;
    end
  end

  // Registered element output
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ov_q <= 1'b0;
      okind_q <= trc_pkg::EL_NONE;
      oaddr_q <= trc_pkg::ADDR_RST;
      otype_q <= 9'h000;
      ofault_q <= 3'h0;
      ospec_q <= 1'b0;
      okey_q <= trc_pkg::KEY_RST;
      octx_q <= 1'b0;
    end else begin
      ov_q <= ov_d;
      okind_q <= okind_d;
      oaddr_q <= oaddr_d;
      otype_q <= otype_d;
      ofault_q <= ofault_d;
      ospec_q <= ospec_d;
      okey_q <= okey_d;
      octx_q <= octx_d;
    end
  end

  assign elem_valid_o = ov_q;
  assign elem_kind_o = okind_q;
  assign elem_addr_o = oaddr_q;
  assign elem_exc_type_o = otype_q;
  assign elem_fault_o = ofault_q;
  assign elem_spec_o = ospec_q;
  assign elem_key_o = okey_q;
  assign ctx_req_o = octx_q;
  assign locked_o = lock_q;

  // Checks beside the logic
  AST_LOCK_QUIET: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    lock_q && ce_i && !exc_taken_i && !lockup_i && !sec_q && !apend_q
    |=> !ov_q) else $error("element emitted while locked up");
  AST_TAIL_PRA: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    acc && exc_start_i && !lock_q && exc_kind_i == trc_pkg::EK_TAIL_CHAIN
    |=> ppra_q == trc_pkg::NO_EXEC_ADDR) else $error("tail-chain address");
  AST_RETERR_PRA: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    acc && exc_start_i && !lock_q && exc_kind_i == trc_pkg::EK_RET_ERROR
    |=> ppra_q == trc_pkg::NO_EXEC_ADDR) else $error("return error address");
  AST_REPLACE_KEEP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    acc && pend_q && exc_replace_i && !exc_start_i && !lockup_i
    |=> ppra_q == $past(ppra_q) && ptype_q == $past(exc_type_i))
    else $error("replacement lost return address");
  AST_LOCK_EXIT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    acc && exc_start_i && lock_q |=> ppra_q == laddr_q)
    else $error("lockup exit address");
  AST_ENTRY_LOCK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    acc && lockup_i && trace_active_i && pend_q &&
    lockup_cause_i == trc_pkg::LC_ENTRY
    |=> okind_q == trc_pkg::EL_EXC ##1 (ov_q && otype_q == trc_pkg::LOCKUP_TYPE
    && oaddr_q == trc_pkg::NO_EXEC_ADDR)) else $error("entry lockup order");
  AST_LOCK_ADDR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    acc && lockup_i && trace_active_i && lockup_cause_i == trc_pkg::LC_INSN
    |=> ov_q && oaddr_q == $past(lockup_addr_i)) else $error("lockup address");
  AST_ADDR_FIRST: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && apend_q && !sec_q |=> ov_q && okind_q == trc_pkg::EL_ADDR)
    else $error("pending address not emitted first");
  AST_FAULT_BITS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    acc && exc_taken_i && pend_q && trace_active_i && !lockup_i
    |=> elem_fault_o == $past(faults)) else $error("fault bits wrong");
  AST_NO_KEY_FULL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ov_q && okind_q == trc_pkg::EL_EXRET && !mcu_profile_i |-> !ospec_q)
    else $error("full-profile return keyed");

  COV_TAKEN: cover property (@(posedge clk_i) ov_q && okind_q == trc_pkg::EL_EXC);
  COV_LOCK: cover property (@(posedge clk_i) lock_q ##1 !lock_q);
  COV_EXRET: cover property (@(posedge clk_i) okind_q == trc_pkg::EL_EXRET);
  COV_ADDR: cover property (@(posedge clk_i) okind_q == trc_pkg::EL_ADDR);
endmodule : exc_trace_gen

// ==== verilog/exret_detect.sv ====
`timescale 1ns/1ps
// Recognises exception returns by instruction class and loaded PC value
module exret_detect (
  input wire logic mcu_profile_i,
  input wire trc_pkg::insn_class_type class_i,
  input wire logic [31:0] pc_load_i,
  input wire logic cond_fail_i,
  output logic is_exret_o
);
  wire magic_pc;
  wire pc_writer;
  wire full_ret;

  // Opcode alone is not enough on microcontrollers: the value decides
  assign magic_pc = (pc_load_i[31:28] == trc_pkg::EXRET_TOP);
  assign pc_writer = (class_i == trc_pkg::IC_MULTI_LOAD_PC) ||
                     (class_i == trc_pkg::IC_SINGLE_LOAD_PC) ||
                     (class_i == trc_pkg::IC_REG_BRANCH_EXCHANGE);
  // Condition-failed returns are still reported on full profiles, which is permitted; microcontroller ones are not
  assign full_ret = (class_i == trc_pkg::IC_ERET);
  assign is_exret_o = mcu_profile_i ? (pc_writer && magic_pc && !cond_fail_i)
                                    : full_ret;
endmodule : exret_detect

// ==== verilog/trc_pkg.sv ====
// Behaviour
// - Late arrival: trace only the late exception.
// - Tail-chain return address 0xFFFFFFE.
// - Lockup while tracing: lockup exception at lockup address.
// - No speculation points while locked up.
// - Exit from lockup traced with lockup address.
// - Derived on entry: trace final one, original return address.
// - Entry lockup: exception, then lockup at 0xFFFFFFE.
// - Return-error derived: tail-chain style, return kept.
// - Return-error lockup: lockup at 0xFFFFFFE.
// - Late normal over derived keeps original return address.
// - Exception type flags pending severe faults.
// - Full profiles: unkeyed return follows its atom.
// - Condition-failed return may be reported.
// - Microcontroller return is a keyed speculation point.
// - Microcontroller return: 0xF------- loaded into PC.
// - Address when next address not inferable.
// - Address before next atom, Q or exception.
// - Optional address after trace-info or trace-on.
// - Entering 64-bit state requests a context element.
// - Tagged addresses drop the tag.
// - Invalid addresses traced in full.
// - No redundant address elements.
package trc_pkg;
  localparam int ADDR_W = 64;
  localparam int TYPE_W = 9;
  localparam int KEY_W = 4;
  localparam logic [63:0] NO_EXEC_ADDR = 64'h0000_0000_0FFF_FFFE;
  localparam logic [3:0] EXRET_TOP = 4'hF;
  localparam logic [15:0] CANON_LO = 16'h0000;
  localparam logic [15:0] CANON_HI = 16'hFFFF;
  localparam logic [TYPE_W-1:0] LOCKUP_TYPE = 9'h1FF;
  localparam logic [KEY_W-1:0] KEY_RST = 4'h0;
  localparam logic [63:0] ADDR_RST = 64'h0000_0000_0000_0000;

  typedef enum logic [2:0] {
    EL_NONE, EL_ATOM_E, EL_ATOM_N, EL_Q, EL_EXC, EL_EXRET, EL_ADDR
  } elem_kind_type;

  typedef enum logic [2:0] {
    IC_OTHER, IC_DIRECT, IC_INDIRECT, IC_SYNC_BARRIER, IC_MULTI_LOAD_PC,
    IC_SINGLE_LOAD_PC, IC_REG_BRANCH_EXCHANGE, IC_ERET
  } insn_class_type;

  typedef enum logic [1:0] {
    EK_NORMAL, EK_TAIL_CHAIN, EK_RET_ERROR
  } exc_kind_type;

  typedef enum logic [1:0] {
    LC_INSN, LC_ENTRY, LC_RETURN
  } lock_cause_type;
endpackage : trc_pkg
